// ### shared/sar_pkg.sv
// Summary of operation
// - With cascade select low the shared pin acts as an enable that turns the serial output on or off.
// - With cascade select high the shared pin carries serial data from the next converter in the chain.
// - A rising edge on the convert strobe wakes the converter and starts a new conversion.
// - Busy rises when a conversion starts and falls once it has completed.
// - While the output is enabled, result or chained data leaves MSB first, one bit per serial clock rise.
// - The 18-bit result shifted out is a two's complement number.
// - Gain squeeze select low maps full scale to 10% to 90% of the reference range, high uses the full range.
// - With gain squeeze active the codes are remapped so zero scale is 0.1 and full scale 0.9 of the reference.
// - A conversion resolves 18 bits by successive approximation and then prepares the code for shifting.
// - The converter alternates between acquisition and a conversion phase started by the strobe.
// - Conversion is timed internally; the host supplies no conversion clock.
// - A result is ready for readout before the next conversion starts, with no cycle latency.
// - The converter powers down between conversions until the next strobe rising edge.
`default_nettype none

package sar_pkg;

    // Converter geometry
    localparam int         SAR_BITS      = 18;
    localparam logic [4:0] SAR_STEP_TOP  = 5'h11;
    localparam logic [4:0] SAR_STEP_LAST = 5'h00;

    // Values after reset
    localparam logic [17:0] SAR_CODE_RST = 18'h00000;
    localparam logic        SAR_TOG_RST  = 1'h0;

    // Gain squeeze: output = raw + raw/4, a gain of 1.25 = 1/0.8
    localparam int SAR_SQUEEZE_SHIFT = 2;

    // Approximation steps, one cycle per bit; done shows one cycle after the last step
    localparam int SAR_CONV_CYCLES = SAR_BITS;

    // Control states
    typedef enum logic [1:0] {
        SAR_ST_SLEEP = 2'b00,
        SAR_ST_CONV  = 2'b01,
        SAR_ST_FIX   = 2'b10
    } sar_state_t;

endpackage

`default_nettype wire

// ### shared/sar_if.sv
`default_nettype none

// Carries one approximation run between control and engine
interface sar_if #(parameter int BITS = 18);
    logic            start;
    logic            above;
    logic            done;
    logic [BITS-1:0] trial;
    logic [BITS-1:0] code;

    modport ctrl   (output start, output above, input done, input trial, input code);
    modport engine (input start, input above, output done, output trial, output code);
endinterface

`default_nettype wire

// ### core/sar_engine.sv
`default_nettype none

module sar_engine
    import sar_pkg::*;
#(
    parameter int BITS = SAR_BITS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Control side
    sar_if.engine    sar
);

    logic [BITS-1:0] code;
    logic [4:0]      step;
    logic            active;
    logic            done;
    wire  [BITS-1:0] one_hot = BITS'(1) << step;
    wire             last    = active && (step == SAR_STEP_LAST);

    // Trial weight halves each step: ref/2, ref/4 ... ref/262144
    assign sar.trial = code | one_hot;
    assign sar.code  = code;
    assign sar.done  = done;

    // One bit resolved per internal clock, no host clock involved
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            code   <= SAR_CODE_RST;
            step   <= SAR_STEP_TOP;
            active <= 1'b0;
            done   <= 1'b0;
        end else if (sar.start) begin
            code   <= SAR_CODE_RST;
            step   <= SAR_STEP_TOP;
            active <= 1'b1;
            done   <= 1'b0;
        end else begin
            if (active && sar.above) code <= sar.trial;
            if (active) step <= step - 5'h01;
            active <= active && !last;
            done   <= last;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Start edge loads step 17; step 0 is resolved at the 18th edge, done shows at the 19th
    a_sar_length: assert property (sar.start |-> ##19 sar.done)
        else $error("approximation did not finish in 19 cycles");
    a_sar_keep: assert property (active && !sar.start && sar.above |=> (code & $past(one_hot)) != '0)
        else $error("trial bit not kept when comparator is above");

endmodule // sar_engine

`default_nettype wire

// ### core/sar_adc_top.sv
`default_nettype none

module sar_adc_top
    import sar_pkg::*;
#(
    parameter int BITS = SAR_BITS
) (
    // Clocks and reset
    input  wire logic            clk_sys,
    input  wire logic            srst,
    input  wire logic            link_sck,
    // Converter control pins
    input  wire logic            convert_strobe,
    input  wire logic            cascade_select,
    input  wire logic            read_enable_or_cascade_in,
    input  wire logic            gain_squeeze_select,
    // Comparator and capacitor array
    input  wire logic            cmp_above,
    output logic      [BITS-1:0] sampling_cap_array,
    // Status
    output logic                 busy,
    output logic                 power_down,
    output logic                 sample_enable,
    // Serial output
    output logic                 sdo,
    output logic                 sdo_oe
);

    // Pin bit positions inside the synchroniser
    localparam int PIN_CNV = 0;
    localparam int PIN_CAS = 1;
    localparam int PIN_RDE = 2;
    localparam int PIN_GSQ = 3;
    localparam int NPINS   = 4;

    sar_if #(.BITS(BITS)) sar ();

    sar_state_t        state;
    sar_state_t        next_state;
    logic [NPINS-1:0]  pin_s1;
    logic [NPINS-1:0]  pin_s2;
    logic              cnv_d;
    logic [BITS-1:0]   result_word;
    logic              conv_tog;
    logic              start_pulse;

    // Control pins come from outside, two flops each
    wire [NPINS-1:0] pin_raw = {gain_squeeze_select, read_enable_or_cascade_in,
                                cascade_select, convert_strobe};

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                end
            end
        end
    endgenerate

    // Named decodes of the synchronised pins
    wire cnv_s     = pin_s2[PIN_CNV];
    wire chain_on  = pin_s2[PIN_CAS];
    wire rd_low    = !pin_s2[PIN_RDE];
    wire squeeze   = !pin_s2[PIN_GSQ];
    wire cnv_rise  = cnv_s && !cnv_d;
    wire idle      = (state == SAR_ST_SLEEP);
    wire take      = idle && cnv_rise;

    // Strobe edge detector; reads the second flop only
    always_ff @(posedge clk_sys) begin
        if (srst) cnv_d <= 1'b0;
        else      cnv_d <= cnv_s;
    end

    // Edges during a conversion are ignored; the host must space them
    always_comb begin
        next_state = state;
        case (state)
            SAR_ST_SLEEP: if (cnv_rise) next_state = SAR_ST_CONV;
            SAR_ST_CONV:  if (sar.done) next_state = SAR_ST_FIX;
            SAR_ST_FIX:   next_state = SAR_ST_SLEEP;
            default:      next_state = SAR_ST_SLEEP;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) state <= SAR_ST_SLEEP;
        else      state <= next_state;
    end

    // Busy is high exactly while not in the sleep state
    always_ff @(posedge clk_sys) begin
        if (srst) busy <= 1'b0;
        else      busy <= (next_state != SAR_ST_SLEEP);
    end

    // Sampling and sleep share the idle phase; array wakes only to convert
    assign sample_enable = idle;
    assign power_down    = idle;

    // Engine hookup: start on the accepted edge, comparator fed back
    assign start_pulse        = take;
    assign sar.start          = start_pulse;
    assign sar.above          = cmp_above;
    assign sampling_cap_array = sar.trial;

    sar_engine #(.BITS(BITS)) sar_engine_inst (
        .clk_sys (clk_sys),
        .srst    (srst),
        .sar     (sar)
    );

    // Offset binary from the array becomes two's complement by MSB flip
    wire signed [BITS-1:0] raw_tc  = {~sar.code[BITS-1], sar.code[BITS-2:0]};
    wire signed [BITS+1:0] raw_w   = (BITS+2)'(raw_tc);
    wire signed [BITS+1:0] gain_w  = raw_w + (raw_w >>> SAR_SQUEEZE_SHIFT);
    wire signed [BITS+1:0] max_w   = (BITS+2)'({1'b0, {(BITS-1){1'b1}}});
    wire signed [BITS+1:0] min_w   = -max_w - (BITS+2)'(1);
    wire                   hi_clip = gain_w > max_w;
    wire                   lo_clip = gain_w < min_w;

    // Saturate the 1.25 gain so 10%/90% inputs land on the end codes
    wire [BITS-1:0] squeezed = hi_clip ? max_w[BITS-1:0] :
                               lo_clip ? min_w[BITS-1:0] : gain_w[BITS-1:0];
    wire [BITS-1:0] final_code = squeeze ? squeezed : raw_tc;

    // Result is latched as busy falls, so readout needs no extra cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            result_word <= SAR_CODE_RST;
            conv_tog    <= SAR_TOG_RST;
        end else if (state == SAR_ST_FIX) begin
            result_word <= final_code;
            conv_tog    <= !conv_tog;
        end
    end

    // Normal mode: low enable turns the output on; chain mode always on
    always_ff @(posedge clk_sys) begin
        if (srst) sdo_oe <= 1'b0;
        else      sdo_oe <= chain_on || rd_low;
    end

    // Link side, clocked by the host's serial clock

    logic            lrst_s1;
    logic            lrst;
    logic            cas_l1;
    logic            cas_l2;
    logic            seen_tog;
    logic [BITS-1:0] shreg;

    // Reset and mode cross into the link domain through two flops
    always_ff @(posedge link_sck) begin
        lrst_s1 <= srst;
        lrst    <= lrst_s1;
        cas_l1  <= cascade_select;
        cas_l2  <= cas_l1;
    end

    // The result word and its toggle are held still while busy is low,
    // so the link side may read them without a word synchroniser
    wire fresh    = (conv_tog != seen_tog);
    wire chain_in = cas_l2 ? read_enable_or_cascade_in : 1'b0;

    // First edge of a frame loads the result, later edges shift
    always_ff @(posedge link_sck) begin
        if (lrst) begin
            seen_tog <= SAR_TOG_RST;
            shreg    <= SAR_CODE_RST;
        end else if (fresh) begin
            seen_tog <= conv_tog;
            shreg    <= {result_word[BITS-2:0], chain_in};
        end else begin
            shreg    <= {shreg[BITS-2:0], chain_in};
        end
    end

    // MSB stands before the first edge; chained bits follow the 18th
    assign sdo = fresh ? result_word[BITS-1] : shreg[BITS-1];

    // Checks in the system domain

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_start;
        idle && cnv_rise;
    endsequence

    sequence s_busy_run;
        busy [*8];
    endsequence

    sequence s_finish;
        busy ##1 !busy;
    endsequence

    sequence s_prepare;
        state == SAR_ST_FIX;
    endsequence

    a_busy_rises: assert property (s_start |=> busy)
        else $error("busy did not rise after strobe edge");

    // Busy stands for exactly 20 cycles: 8 counted here, 12 more, then it drops
    a_conv_span: assert property (s_start |=> s_busy_run ##12 s_finish)
        else $error("conversion length wrong");

    a_edge_wakes: assert property (s_start |-> ##1 !power_down && !sample_enable)
        else $error("strobe edge did not wake the converter");

    a_busy_falls: assert property (state == SAR_ST_FIX |=> !busy && power_down)
        else $error("busy not low after completion");

    a_sleep_after: assert property ($fell(busy) |-> power_down ##1 (power_down || busy))
        else $error("not powered down between conversions");

    a_acq_phase: assert property (sample_enable |-> !busy)
        else $error("sampling while converting");

    a_no_latency: assert property ($fell(busy) |-> conv_tog != $past(conv_tog, 1))
        else $error("result not published when busy fell");

    a_full_range: assert property (state == SAR_ST_FIX && !squeeze |=> result_word == $past(raw_tc))
        else $error("full range result altered");

    a_squeeze_map: assert property (state == SAR_ST_FIX && squeeze |=> result_word == $past(squeezed))
        else $error("gain squeeze mapping wrong");

    a_twos_sign: assert property (state == SAR_ST_FIX && !squeeze |=> result_word[BITS-1] == !$past(sar.code[BITS-1]))
        else $error("sign bit not two's complement");

    a_oe_normal: assert property (!chain_on && !rd_low |=> !sdo_oe)
        else $error("output enabled with read enable high");

    a_oe_chain: assert property (chain_on |=> sdo_oe)
        else $error("output not enabled in chain mode");

    a_oe_on: assert property (!chain_on && rd_low |=> sdo_oe)
        else $error("output not enabled with read enable low");

    // Conversion walk: one trial bit at a time, half-scale weight first
    a_first_trial: assert property (s_start |=> sampling_cap_array == {1'b1, {(BITS-1){1'b0}}})
        else $error("first trial is not the half-scale weight");

    a_one_trial: assert property (state == SAR_ST_CONV && !sar.done |-> $onehot(sar.trial ^ sar.code))
        else $error("trial differs from code in more than one bit");

    a_done_in_conv: assert property (sar.done |-> state == SAR_ST_CONV)
        else $error("approximation done outside a conversion");

    a_busy_steady: assert property (state == SAR_ST_CONV |-> busy)
        else $error("busy low during conversion");

    // Sleep is left only through an accepted strobe edge and entered right after the fix-up cycle
    a_sleep_span: assert property (power_down && !cnv_rise |=> power_down)
        else $error("woke without a strobe edge");

    a_strobe_only: assert property ($fell(power_down) |-> $past(cnv_rise))
        else $error("conversion started without a strobe edge");

    a_fix_once: assert property (s_prepare |=> idle)
        else $error("no return to sleep after the result was prepared");

    // The link side reads these without a synchroniser, so they must not move between conversions
    a_result_still: assert property (state != SAR_ST_FIX |=> $stable(result_word) && $stable(conv_tog))
        else $error("result moved outside the fix-up cycle");

    // Clipped inputs must land exactly on the end codes
    a_squeeze_top: assert property (s_prepare ##0 (squeeze && hi_clip)
        |=> result_word == {1'b0, {(BITS-1){1'b1}}})
        else $error("upper clip not on the top code");

    a_squeeze_floor: assert property (s_prepare ##0 (squeeze && lo_clip)
        |=> result_word == {1'b1, {(BITS-1){1'b0}}})
        else $error("lower clip not on the bottom code");

    // Checks in the link domain, on the host's serial clock
    a_msb_first: assert property (@(posedge link_sck) disable iff (lrst)
        fresh |=> sdo == $past(result_word[BITS-2]))
        else $error("second bit out of order");

    // A new result may arrive between two frames, so a fresh word excuses the shift
    a_shift_on: assert property (@(posedge link_sck) disable iff (lrst)
        !fresh |=> fresh || sdo == $past(shreg[BITS-2]))
        else $error("shift register skipped a bit");

    a_chain_input: assert property (@(posedge link_sck) disable iff (lrst)
        cas_l2 |=> shreg[0] == $past(read_enable_or_cascade_in))
        else $error("chained bit not taken in");

    a_normal_zero: assert property (@(posedge link_sck) disable iff (lrst)
        !cas_l2 |=> !shreg[0])
        else $error("pin data shifted in normal mode");

endmodule // sar_adc_top

`default_nettype wire

// ### sim/sar_host_model.sv
`default_nettype none

module sar_host_model
    import sar_pkg::*;
(
    // Converter side
    input  wire logic        clk_sys,
    input  wire logic [17:0] sampling_cap_array,
    input  wire logic        sample_enable,
    output logic             cmp_above,
    output logic             link_sck,
    // Bench side
    input  wire logic [17:0] analog_level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [17:0] held_level;

    // Track the input only in acquisition, so a late change cannot leak into a conversion
    always @(posedge clk_sys) begin
        if (sample_enable) begin
            held_level <= analog_level;
        end
    end

    // Ideal comparator, one when the held input reaches the trial
    assign cmp_above = (held_level >= sampling_cap_array);

    // Shift clock stands still low between frames
    initial begin
        link_sck = 1'b0;
    end

    // Host clocks n bits at 6 ns, without waiting for busy to fall
    task automatic clock_bits(input int n);
        for (int i = 0; i < n; i++) begin
            #3 link_sck = 1'b1;
            #3 link_sck = 1'b0;
        end
    endtask
endmodule // sar_host_model

`default_nettype wire

// ### sim/sar_adc_conversion_serial_readout_tb.sv
`default_nettype none

module sar_adc_conversion_serial_readout_tb;
    import sar_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys, srst, link_sck, convert_strobe, cascade_select;
    logic        read_enable_or_cascade_in, gain_squeeze_select, cmp_above;
    logic [17:0] sampling_cap_array, analog_level;
    logic        busy, power_down, sample_enable, sdo, sdo_oe;
    int          n_fail;
    int          check_count;

    sar_adc_top sar_adc_top_inst (.clk_sys(clk_sys), .srst(srst), .link_sck(link_sck),
        .convert_strobe(convert_strobe), .cascade_select(cascade_select),
        .read_enable_or_cascade_in(read_enable_or_cascade_in), .gain_squeeze_select(gain_squeeze_select),
        .cmp_above(cmp_above), .sampling_cap_array(sampling_cap_array), .busy(busy),
        .power_down(power_down), .sample_enable(sample_enable), .sdo(sdo), .sdo_oe(sdo_oe));

    sar_host_model sar_host_model_inst (.clk_sys(clk_sys), .sampling_cap_array(sampling_cap_array),
        .sample_enable(sample_enable), .cmp_above(cmp_above), .link_sck(link_sck),
        .analog_level(analog_level));

    // 10 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Offset-binary level to two's complement, scaled by 1.25 and clipped when squeezing
    function automatic logic [17:0] expect_code(input logic [17:0] lvl, input logic squeeze_on);
        logic signed [19:0] raw;
        logic signed [19:0] sum;
        raw = {{3{~lvl[17]}}, lvl[16:0]};
        sum = raw + (raw >>> 2);
        if (!squeeze_on) return raw[17:0];
        if (sum > 20'sd131071) return 18'h1ffff;
        if (sum < -20'sd131072) return 18'h20000;
        return sum[17:0];
    endfunction

    // One conversion and readout; poke strobes again mid-conversion, chain feeds a tail
    task automatic conv_read(input logic [17:0] lvl, input logic sel, input logic poke, input logic chain);
        logic [17:0] exp;
        logic [3:0]  pat;
        int          n;
        exp = expect_code(lvl, ~sel);
        pat = chain ? 4'hb : 4'h0;
        @(negedge clk_sys);
        analog_level = lvl;
        gain_squeeze_select = sel;
        convert_strobe = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 8) begin
            n_fail++;
            report_and_stop();
        end
        check(n >= 3 && n <= 4, 1'b1);
        check(sampling_cap_array, 18'h20000);
        check({power_down, sample_enable}, 2'h0);
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            if (n == 2) convert_strobe = 1'b0;
            if (poke && n == 6) convert_strobe = 1'b1;
            if (poke && n == 10) convert_strobe = 1'b0;
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40) begin
            n_fail++;
            report_and_stop();
        end
        check(n, 20);
        check({power_down, sample_enable}, 2'h3);
        check(sdo_oe, 1'b1);
        // Bits leave MSB first; after 18 edges the chained data or zero follows
        for (int k = 0; k < 22; k++) begin
            check(sdo, (k < 18) ? exp[17-k] : pat[k-18]);
            if (chain) read_enable_or_cascade_in = pat[k % 4];
            sar_host_model_inst.clock_bits(1);
        end
        check(busy, 1'b0);
        $display("test conversion %h done", lvl);
    endtask

    task automatic enable_check();
        @(negedge clk_sys);
        read_enable_or_cascade_in = 1'b1;
        repeat (5) @(negedge clk_sys);
        check(sdo_oe, 1'b0);
        read_enable_or_cascade_in = 1'b0;
        repeat (5) @(negedge clk_sys);
        check(sdo_oe, 1'b1);
        $display("test enable done");
    endtask

    initial begin
        n_fail = 0;
        check_count = 0;
        srst = 1'b1;
        convert_strobe = 1'b0;
        cascade_select = 1'b0;
        read_enable_or_cascade_in = 1'b0;
        gain_squeeze_select = 1'b1;
        analog_level = 18'h00000;
        // Link side resets through its own copy, so it needs edges of its own
        sar_host_model_inst.clock_bits(4);
        repeat (5) @(negedge clk_sys);
        check({busy, power_down, sample_enable, sdo_oe, sdo}, 5'h0c);
        srst = 1'b0;
        // The link copy of reset clears only on serial clock edges of its own
        sar_host_model_inst.clock_bits(3);
        $display("test reset done");
        conv_read(18'h00000, 1'b0, 1'b0, 1'b0);
        conv_read(18'h3ffff, 1'b0, 1'b0, 1'b0);
        conv_read(18'h2a000, 1'b0, 1'b0, 1'b0);
        conv_read(18'h15555, 1'b1, 1'b0, 1'b0);
        conv_read(18'h20000, 1'b1, 1'b1, 1'b0);
        enable_check();
        @(negedge clk_sys);
        cascade_select = 1'b1;
        repeat (5) @(negedge clk_sys);
        // Mode reaches the link side only through serial clock edges
        sar_host_model_inst.clock_bits(3);
        conv_read(18'h0f0f3, 1'b1, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule // sar_adc_conversion_serial_readout_tb

`default_nettype wire
